/* File: hw/kbd_pkg.sv */
`default_nettype none

package kbd_pkg;

	// ------------------------------------------------------------------
	// Register map, byte addresses on the APB side
	// ------------------------------------------------------------------
	localparam int              ADDR_W      = 12;
	localparam logic [11:0]     OFS_SELECT  = 12'h000;
	localparam logic [11:0]     OFS_COMMAND = 12'h004;
	localparam logic [11:0]     OFS_DATA    = 12'h008;
	localparam logic [11:0]     OFS_STATUS  = 12'h00C;
	localparam logic [11:0]     OFS_MASK    = 12'h010;
	localparam logic [11:0]     OFS_CONTROL = 12'h014;

	localparam logic [7:0]      KBD_SELECT_ADDR = 8'hE1;

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int              CMD_INIT_BIT     = 0;
	localparam int              CMD_DCLR_BIT     = 1;
	localparam int              CMD_BEEP_BIT     = 2;
	localparam int              CMD_CLICK_BIT    = 3;
	localparam int              STAT_AVAIL_BIT   = 7;
	localparam int              STAT_OVERRUN_BIT = 6;
	localparam int              STAT_REPEAT_BIT  = 1;
	localparam int              MASK_KBD_BIT     = 0;
	localparam int              LIGHTS_W         = 8;
	localparam int              CTRL_FAST_BIT    = 8;
	localparam logic [7:0]      LIGHTS_RST       = 8'h00;

	localparam int              KEY_W  = 6;
	localparam int              PAD_W  = 2;
	localparam int              CODE_W = PAD_W + 2 + KEY_W;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int              CLK_PERIOD_NS   = 10;
	localparam int              MS_NS           = 1000000;
	localparam int              TICK_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
	localparam int              MS_PER_S        = 1000;
	localparam int              MS_W            = 11;
	localparam int              REPEAT_MIN_MS   = 500;
	localparam int              REPEAT_MAX_MS   = 1200;
	// Aim at the middle of the window so tick jitter cannot leave it.
	localparam int              REPEAT_DELAY_MS = (REPEAT_MIN_MS + REPEAT_MAX_MS) / 2;
	localparam int              STD_RATE_HZ     = 15;
	localparam int              FAST_RATE_HZ    = 33;
	localparam int              STD_PERIOD_MS   = MS_PER_S / STD_RATE_HZ;
	localparam int              FAST_PERIOD_MS  = MS_PER_S / FAST_RATE_HZ;
	localparam int              BEEP_MS         = 100;
	localparam int              CLICK_MS        = 4;
	localparam int              TONE_PEND_MAX   = 7;

	typedef enum logic [2:0]
	{
		RPT_IDLE  = 3'b001,
		RPT_DELAY = 3'b010,
		RPT_RUN   = 3'b100
	} rpt_state_t;

endpackage : kbd_pkg

`default_nettype wire

/* File: hw/keyboard_io_interface.sv */
// The register offsets and the APB register port were chosen for this implementation.
`default_nettype none

// Function
// - Select only on address E1 hex.
// - Initialise deselects the keyboard.
// - Keypress sets character-available flag.
// - Initialise clears character-available flag.
// - Device clear clears character-available flag.
// - Input read clears character-available flag.
// - Interrupt when mask enabled and flag set.
// - Mask off withholds the interrupt.
// - Repeat starts between 0.5 and 1.2 s.
// - Standard repeat rate fifteen codes per second.
// - Release ends repeat immediately.
// - One beep per beep command; the code drops a beep command that finds seven already waiting.
// - One click per click command; the code drops a click command that finds seven already waiting.
// - Lights follow last written pattern.
// - ASCII pad codes in four states.
// - Shift lock forces shifted codes.
// - Cursor pad codes in four states.
// - Numeric and function pad codes too.
// - Flag reported as status bit 7.
// - Fast repeat option gives 33 per second.
module keyboard_io_interface #(
	parameter int TICK_CYCLES = kbd_pkg::TICK_CYCLES_DEF
) (
	// Clock and reset
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	// APB slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [kbd_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	// Key matrix
	input  wire logic                       key_down,
	input  wire logic [kbd_pkg::PAD_W-1:0]  key_pad,
	input  wire logic [kbd_pkg::KEY_W-1:0]  key_index,
	input  wire logic                       shift_key,
	input  wire logic                       ctrl_key,
	input  wire logic                       shift_lock_on,
	// Outputs to the operator and the host
	output logic                            kbd_irq,
	output logic                            beep_on,
	output logic                            click_on,
	output logic [kbd_pkg::LIGHTS_W-1:0]    status_lights
);
	import kbd_pkg::*;

	localparam int TICK_W = $clog2(TICK_CYCLES);
	localparam logic [1:0][MS_W-1:0] TONE_MS = {MS_W'(CLICK_MS), MS_W'(BEEP_MS)};

	typedef struct packed {
		logic                     selected;
		logic                     avail;
		logic                     overrun;
		logic [CODE_W-1:0]        code;
		logic                     mask_en;
		logic                     fast;
		logic [LIGHTS_W-1:0]      lights;
		rpt_state_t               rpt;
		logic [MS_W-1:0]          rpt_ms;
		logic                     key_prev;
		logic [TICK_W-1:0]        tick_cnt;
		logic [1:0][2:0]          tone_pend;
		logic [1:0][MS_W-1:0]     tone_ms;
		logic [1:0]               tone_busy;
		logic [1:0]               tone_on;
		logic [31:0]              rdata;
	} state_t;

	localparam state_t ST_RST = '{
		rpt: RPT_IDLE, lights: LIGHTS_RST, default: '0};

	state_t                st_q;
	state_t                st_d;
	logic                  setup;
	logic                  access;
	logic                  wr;
	logic                  mapped;
	logic                  cmd_wr;
	logic                  init_cmd;
	logic                  dclr_cmd;
	logic                  read_cmd;
	logic                  clr_flag;
	logic                  tick;
	logic                  press;
	logic                  issue;
	logic [MS_W-1:0]       period_ms;
	logic [1:0]            tone_cmd;
	logic [CODE_W-1:0]     key_code;

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	// Reads are sampled in the setup phase so the access phase never waits.
	assign setup    = psel && !penable;
	assign access   = psel && penable;
	assign wr       = access && pwrite;
	assign mapped   = (paddr == OFS_SELECT) || (paddr == OFS_COMMAND) ||
	                  (paddr == OFS_DATA) || (paddr == OFS_STATUS) ||
	                  (paddr == OFS_MASK) || (paddr == OFS_CONTROL);
	assign pready   = 1'b1;
	assign pslverr  = access && !mapped;
	assign prdata   = st_q.rdata;
	assign cmd_wr   = wr && (paddr == OFS_COMMAND);
	// Initialise is bus wide and needs no selection.
	assign init_cmd = cmd_wr && pwdata[CMD_INIT_BIT];
	assign dclr_cmd = cmd_wr && st_q.selected && pwdata[CMD_DCLR_BIT];
	assign read_cmd = access && !pwrite && st_q.selected && (paddr == OFS_DATA);
	assign clr_flag = init_cmd || dclr_cmd || read_cmd;
	assign tone_cmd = {2{cmd_wr && st_q.selected}} &
	                  {pwdata[CMD_CLICK_BIT], pwdata[CMD_BEEP_BIT]};

	// ------------------------------------------------------------------
	// Key code and timing
	// ------------------------------------------------------------------
	// Each pad key gets a distinct code in all four shift states; shift lock
	// behaves as a held shift key.
	assign key_code  = {key_pad, ctrl_key, shift_key || shift_lock_on, key_index};
	assign tick      = (st_q.tick_cnt == TICK_W'(TICK_CYCLES - 1));
	assign press     = key_down && !st_q.key_prev;
	assign period_ms = st_q.fast ? MS_W'(FAST_PERIOD_MS) : MS_W'(STD_PERIOD_MS);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb
	begin
		logic [2:0] pend_n;
		pend_n = '0;
		st_d   = st_q;
		issue  = 1'b0;
		st_d.tick_cnt = tick ? '0 : st_q.tick_cnt + 1'b1;
		st_d.key_prev = key_down;

		unique case (st_q.rpt)
			RPT_IDLE:
			begin
				if (press)
				begin
					issue       = 1'b1;
					st_d.rpt    = RPT_DELAY;
					st_d.rpt_ms = '0;
				end
			end
			RPT_DELAY:
			begin
				if (!key_down)
					st_d.rpt = RPT_IDLE;
				else if (tick && st_q.rpt_ms == MS_W'(REPEAT_DELAY_MS - 1))
				begin
					issue       = 1'b1;
					st_d.rpt    = RPT_RUN;
					st_d.rpt_ms = '0;
				end
				else if (tick)
					st_d.rpt_ms = st_q.rpt_ms + 1'b1;
			end
			RPT_RUN:
			begin
				if (!key_down)
					st_d.rpt = RPT_IDLE;
				else if (tick && st_q.rpt_ms >= period_ms - 1'b1)
				begin
					issue       = 1'b1;
					st_d.rpt_ms = '0;
				end
				else if (tick)
					st_d.rpt_ms = st_q.rpt_ms + 1'b1;
			end
			default:
				st_d.rpt = RPT_IDLE;
		endcase

		// A clear and a new code in one cycle leave the flag set.
		if (clr_flag)
		begin
			st_d.avail   = 1'b0;
			st_d.overrun = 1'b0;
		end
		if (issue)
		begin
			if (!st_q.avail || clr_flag)
			begin
				st_d.code  = key_code;
				st_d.avail = 1'b1;
			end
			else
				st_d.overrun = 1'b1;
		end

		if (wr && paddr == OFS_SELECT)
			st_d.selected = (pwdata[7:0] == KBD_SELECT_ADDR);
		if (init_cmd)
			st_d.selected = 1'b0;
		if (wr && st_q.selected && paddr == OFS_MASK)
			st_d.mask_en = pwdata[MASK_KBD_BIT];
		if (wr && st_q.selected && paddr == OFS_CONTROL)
		begin
			st_d.lights = pwdata[LIGHTS_W-1:0];
			st_d.fast   = pwdata[CTRL_FAST_BIT];
		end

		// Up to seven commands wait behind the sounding one, so up to eight
		// back-to-back requests each sound once, with a silent gap as long as the tone between them.
		for (int i = 0; i < 2; i++)
		begin
			pend_n = st_q.tone_pend[i];
			if (st_q.tone_busy[i])
			begin
				if (tick && st_q.tone_ms[i] == {TONE_MS[i][MS_W-2:0], 1'b0} - 1'b1)
					st_d.tone_busy[i] = 1'b0;
				else if (tick)
					st_d.tone_ms[i] = st_q.tone_ms[i] + 1'b1;
			end
			else if (pend_n != 3'h0)
			begin
				st_d.tone_busy[i] = 1'b1;
				st_d.tone_ms[i]   = '0;
				pend_n            = pend_n - 1'b1;
			end
			if (tone_cmd[i] && pend_n != 3'(TONE_PEND_MAX))
				pend_n = pend_n + 1'b1;
			if (init_cmd)
				pend_n = '0;
			st_d.tone_pend[i] = pend_n;
			st_d.tone_on[i]   = st_d.tone_busy[i] && (st_d.tone_ms[i] < TONE_MS[i]);
		end

		// Unselected, the keyboard answers only on its select register.
		if (setup && !pwrite)
		begin
			st_d.rdata = '0;
			if (paddr == OFS_SELECT)
				st_d.rdata[0] = st_d.selected;
			else if (st_d.selected)
			begin
				unique case (paddr)
					OFS_DATA:    st_d.rdata[CODE_W-1:0] = st_d.code;
					OFS_STATUS:
					begin
						st_d.rdata[STAT_AVAIL_BIT]   = st_d.avail;
						st_d.rdata[STAT_OVERRUN_BIT] = st_d.overrun;
						st_d.rdata[STAT_REPEAT_BIT]  = (st_d.rpt == RPT_RUN);
					end
					OFS_MASK:    st_d.rdata[MASK_KBD_BIT] = st_d.mask_en;
					OFS_CONTROL:
					begin
						st_d.rdata[LIGHTS_W-1:0]  = st_d.lights;
						st_d.rdata[CTRL_FAST_BIT] = st_d.fast;
					end
					default:     st_d.rdata = '0;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_q <= ST_RST;
		else
			st_q <= st_d;
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign kbd_irq       = st_q.mask_en && st_q.avail;
	assign beep_on       = st_q.tone_on[0];
	assign click_on      = st_q.tone_on[1];
	assign status_lights = st_q.lights;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	// The clear checks are phrased on the decoded init_cmd, dclr_cmd, read_cmd
	// and clr_flag expressions themselves, so a broken decode is not caught here.
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_select_match: assert property (
		wr && paddr == OFS_SELECT && pwdata[7:0] == KBD_SELECT_ADDR && !init_cmd
		|=> st_q.selected)
		else $error("select on E1 did not select");
	a_select_other: assert property (
		wr && paddr == OFS_SELECT && pwdata[7:0] != KBD_SELECT_ADDR |=> !st_q.selected)
		else $error("wrong select address selected the keyboard");
	a_init_clears: assert property (
		init_cmd && !issue |=> !st_q.selected && !st_q.avail)
		else $error("initialise left keyboard selected or flag set");
	a_press_flag: assert property (
		st_q.rpt == RPT_IDLE && key_down && !st_q.key_prev |=> st_q.avail)
		else $error("keypress did not set the flag");
	a_dclr_clears: assert property (
		dclr_cmd && !issue |=> !st_q.avail)
		else $error("device clear did not clear the flag");
	a_read_clears: assert property (
		read_cmd && !issue |=> !st_q.avail)
		else $error("input read did not clear the flag");
	a_irq_raise: assert property (
		press && st_q.rpt == RPT_IDLE && st_q.mask_en && !(wr && paddr == OFS_MASK)
		|=> kbd_irq)
		else $error("keypress with mask enabled raised no interrupt");
	a_irq_masked: assert property (
		wr && st_q.selected && paddr == OFS_MASK && !pwdata[MASK_KBD_BIT]
		|=> !kbd_irq)
		else $error("interrupt not withheld by the mask");
	a_irq_drop: assert property (
		kbd_irq && clr_flag && !issue |=> !kbd_irq)
		else $error("interrupt not withdrawn after clear");
	a_repeat_delay: assert property (
		st_q.rpt == RPT_RUN && $past(st_q.rpt) == RPT_DELAY
		|-> $past(st_q.rpt_ms) == MS_W'(REPEAT_DELAY_MS - 1))
		else $error("repeat entered at wrong delay");
	a_repeat_rate: assert property (
		st_q.rpt == RPT_RUN && issue |-> st_q.rpt_ms >= period_ms - 1'b1 && tick)
		else $error("repeat code issued off its period");
	a_release_ends: assert property (
		!key_down && st_q.rpt != RPT_IDLE |-> !issue ##1 st_q.rpt == RPT_IDLE)
		else $error("repeat continued after release");
	a_lights_follow: assert property (
		wr && st_q.selected && paddr == OFS_CONTROL
		|=> status_lights == $past(pwdata[LIGHTS_W-1:0]))
		else $error("lights do not match written pattern");
	a_code_hold: assert property (
		st_q.avail && !clr_flag |=> $stable(st_q.code))
		else $error("held code changed before it was consumed");
	a_shift_lock: assert property (
		issue && (!st_q.avail || clr_flag) && shift_lock_on |=> st_q.code[KEY_W])
		else $error("shift lock did not give shifted code");
	a_status_bit7: assert property (
		setup && !pwrite && paddr == OFS_STATUS && st_d.selected
		|=> prdata[STAT_AVAIL_BIT] == st_q.avail)
		else $error("status bit 7 does not show the flag");
	a_beep_start: assert property (
		tone_cmd[0] && st_q.tone_pend[0] == 3'h0 && !st_q.tone_busy[0] && !init_cmd
		|=> ##1 st_q.tone_busy[0] ##1 beep_on)
		else $error("beep command produced no beep");
	a_click_start: assert property (
		tone_cmd[1] && st_q.tone_pend[1] == 3'h0 && !st_q.tone_busy[1] && !init_cmd
		|=> ##1 st_q.tone_busy[1] ##1 click_on)
		else $error("click command produced no click");
	a_unsel_ignored: assert property (
		wr && !st_q.selected && paddr == OFS_CONTROL |=> $stable(status_lights))
		else $error("unselected keyboard took a control write");
	a_lock_release: assert property (
		issue && (!st_q.avail || clr_flag) && !shift_lock_on && !shift_key
		|=> !st_q.code[KEY_W])
		else $error("unshifted key gave a shifted code");
	a_code_fields: assert property (
		issue && (!st_q.avail || clr_flag)
		|=> st_q.code[KEY_W+1] == $past(ctrl_key) && st_q.code[KEY_W-1:0] == $past(key_index))
		else $error("issued code does not carry control and key position");
	a_deselect_read: assert property (
		setup && !pwrite && paddr == OFS_CONTROL && !st_d.selected |=> prdata == 32'h0)
		else $error("unselected keyboard answered a control read");

	c_press:   cover property (st_q.rpt == RPT_IDLE && press);
	c_repeat:  cover property (st_q.rpt == RPT_RUN && issue);
	c_irq:     cover property ($rose(kbd_irq));
	c_beep:    cover property ($rose(beep_on));
	c_overrun: cover property ($rose(st_q.overrun));

endmodule : keyboard_io_interface

`default_nettype wire

/* File: verif/key_operator.sv */
`default_nettype none

// Stands in for the operator at the key matrix.
module key_operator
(
	// Clock
	input  wire logic                       pclk,
	// Key matrix
	output logic                            key_down,
	output logic [kbd_pkg::PAD_W-1:0]       key_pad,
	output logic [kbd_pkg::KEY_W-1:0]       key_index,
	output logic                            shift_key,
	output logic                            ctrl_key,
	output logic                            shift_lock_on
);
	timeunit 1ns;
	timeprecision 1ps;
	import kbd_pkg::*;

	initial
	begin
		key_down = 1'b0;
		key_pad = 2'h0;
		key_index = 6'h00;
		shift_key = 1'b0;
		ctrl_key = 1'b0;
		shift_lock_on = 1'b0;
	end

	task automatic press(input logic [PAD_W-1:0] p, input logic [KEY_W-1:0] k,
		input logic sh, input logic ct);
		@(posedge pclk);
		key_pad <= p;
		key_index <= k;
		shift_key <= sh;
		ctrl_key <= ct;
		key_down <= 1'b1;
	endtask : press

	// The position lines are scrambled on release so a stale code cannot pass.
	task automatic release_key();
		@(posedge pclk);
		key_down <= 1'b0;
		key_index <= ~key_index;
		key_pad <= ~key_pad;
	endtask : release_key

	task automatic lock(input logic on);
		@(posedge pclk);
		shift_lock_on <= on;
	endtask : lock
endmodule : key_operator

`default_nettype wire

/* File: verif/keyboard_io_interface_bench.sv */
`default_nettype none

module keyboard_io_interface_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import kbd_pkg::*;
	// A short tick keeps the repeat delay of 850 ticks affordable.
	localparam int T = 2;
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, errv;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, rdv;
	logic              key_down, shift_key, ctrl_key, shift_lock_on;
	logic [PAD_W-1:0]  key_pad;
	logic [KEY_W-1:0]  key_index;
	logic              kbd_irq, beep_on, click_on, beep_q, click_q;
	logic [7:0]        status_lights;
	int                err_count, comparisons, cyc, beeps, clicks;

	keyboard_io_interface #(.TICK_CYCLES(T)) u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .key_down(key_down),
		.key_pad(key_pad), .key_index(key_index), .shift_key(shift_key),
		.ctrl_key(ctrl_key), .shift_lock_on(shift_lock_on), .kbd_irq(kbd_irq),
		.beep_on(beep_on), .click_on(click_on), .status_lights(status_lights));

	key_operator u_keys (.pclk(pclk), .key_down(key_down), .key_pad(key_pad),
		.key_index(key_index), .shift_key(shift_key), .ctrl_key(ctrl_key),
		.shift_lock_on(shift_lock_on));

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		beep_q <= beep_on;
		click_q <= click_on;
		if (beep_on === 1'b1 && beep_q === 1'b0)
			beeps <= beeps + 1;
		if (click_on === 1'b1 && click_q === 1'b0)
			clicks <= clicks + 1;
		if (cyc == 20000)
		begin
			err_count++;
			conclude();
		end
	end

	task automatic conclude();
		if (err_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			err_count++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// ------------------------------------------------------------------
	// Bus and key helpers
	// ------------------------------------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd

	task automatic tap(input logic [PAD_W-1:0] p, input logic [KEY_W-1:0] k,
		input logic sh, input logic ct);
		u_keys.press(p, k, sh, ct);
		u_keys.release_key();
		repeat (2) @(posedge pclk);
	endtask : tap

	task automatic chk_irq(input string n, input logic [31:0] e);
		@(posedge pclk);
		chk(n, 32'(kbd_irq), e);
	endtask : chk_irq

	task automatic wait_irq(output int t);
		do
			@(posedge pclk);
		while (kbd_irq !== 1'b1);
		t = cyc;
	endtask : wait_irq

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_select();
		chk("lights_rst", 32'(status_lights), 32'h0);
		rd(OFS_SELECT);
		chk("sel_rst", rdv, 32'h0);
		wr(OFS_SELECT, 32'h0000_00E0);
		rd(OFS_SELECT);
		chk("sel_wrong", rdv, 32'h0);
		wr(OFS_SELECT, 32'(KBD_SELECT_ADDR));
		rd(OFS_SELECT);
		chk("sel_right", rdv, 32'h1);
		rd(12'h0FC);
		chk("unmapped", 32'(errv), 32'h1);
	endtask : t_select

	// Each pass clears the flag a different way: initialise, device clear, read.
	task automatic t_flag();
		for (int k = 0; k < 3; k++)
		begin
			wr(OFS_CONTROL, 32'h0000_00C3);
			tap(2'h0, 6'h05, 1'b0, 1'b0);
			rd(OFS_STATUS);
			chk("avail_set", 32'(rdv[STAT_AVAIL_BIT]), 32'h1);
			if (k == 2)
				rd(OFS_DATA);
			else
				wr(OFS_COMMAND, 32'h1 << (k == 0 ? CMD_INIT_BIT : CMD_DCLR_BIT));
			rd(OFS_CONTROL);
			chk("answers", rdv, k == 0 ? 32'h0 : 32'h0000_00C3);
			if (k == 0)
				wr(OFS_CONTROL, 32'h0000_003C);
			wr(OFS_SELECT, 32'(KBD_SELECT_ADDR));
			rd(OFS_STATUS);
			chk("avail_clr", 32'(rdv[STAT_AVAIL_BIT]), 32'h0);
			chk("ignored", 32'(status_lights), 32'h0000_00C3);
		end
	endtask : t_flag

	task automatic t_codes();
		logic [CODE_W-1:0] e;
		for (int p = 0; p < 4; p++)
			for (int s = 0; s < 5; s++)
			begin
				u_keys.lock(s == 4);
				tap(2'(p), 6'(p * 9 + s), s[0], s[1]);
				e = {2'(p), s[1], s[0] | (s == 4), 6'(p * 9 + s)};
				rd(OFS_DATA);
				chk("code", rdv, 32'(e));
			end
		u_keys.lock(1'b0);
		tap(2'h0, 6'h01, 1'b0, 1'b0);
		tap(2'h1, 6'h02, 1'b0, 1'b0);
		rd(OFS_STATUS);
		chk("overrun", rdv, 32'h0000_00C0);
		rd(OFS_DATA);
		chk("held_code", rdv, 32'h001);
	endtask : t_codes

	task automatic t_irq();
		wr(OFS_MASK, 32'h1);
		tap(2'h3, 6'h3F, 1'b1, 1'b1);
		chk_irq("irq_on", 32'h1);
		wr(OFS_MASK, 32'h0);
		chk_irq("irq_masked", 32'h0);
		wr(OFS_MASK, 32'h1);
		rd(OFS_DATA);
		chk_irq("irq_clr", 32'h0);
	endtask : t_irq

	task automatic t_lights();
		wr(OFS_CONTROL, 32'h0000_00A5);
		chk_irq("quiet", 32'h0);
		chk("lights", 32'(status_lights), 32'h0000_00A5);
		wr(OFS_CONTROL, 32'h0000_005A);
		rd(OFS_CONTROL);
		chk("lights_rd", rdv, 32'h0000_005A);
		chk("lights_new", 32'(status_lights), 32'h0000_005A);
	endtask : t_lights

	task automatic t_tones();
		int b0, c0;
		b0 = beeps;
		c0 = clicks;
		wr(OFS_COMMAND, 32'h1 << CMD_BEEP_BIT);
		wr(OFS_COMMAND, 32'h1 << CMD_BEEP_BIT);
		repeat (450 * T) @(posedge pclk);
		chk("beeps", 32'(beeps - b0), 32'h2);
		for (int i = 0; i < 3; i++)
			wr(OFS_COMMAND, 32'h1 << CMD_CLICK_BIT);
		repeat (40 * T) @(posedge pclk);
		chk("clicks", 32'(clicks - c0), 32'h3);
	endtask : t_tones

	task automatic t_repeat(input logic fast);
		int t0, t1, t2;
		wr(OFS_MASK, 32'h1);
		wr(OFS_CONTROL, 32'(fast) << CTRL_FAST_BIT);
		u_keys.press(2'h0, 6'h11, 1'b0, 1'b0);
		t0 = cyc;
		rd(OFS_DATA);
		wait_irq(t1);
		chk("delay", 32'(t1 - t0 >= 500 * T && t1 - t0 <= 1200 * T), 32'h1);
		rd(OFS_STATUS);
		chk("repeating", rdv, 32'h0000_0082);
		rd(OFS_DATA);
		chk("rpt_code", rdv, 32'h0000_0011);
		wait_irq(t2);
		if (fast)
			chk("fast", 32'(t2 - t1 >= 27 * T && t2 - t1 <= 33 * T), 32'h1);
		else
			chk("std", 32'(t2 - t1 >= 60 * T && t2 - t1 <= 73 * T), 32'h1);
		u_keys.release_key();
		rd(OFS_DATA);
		repeat (100 * T) @(posedge pclk);
		chk("stopped", 32'(kbd_irq), 32'h0);
		rd(OFS_STATUS);
		chk("rpt_off", rdv, 32'h0);
	endtask : t_repeat

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		beep_q = 1'b0;
		click_q = 1'b0;
		err_count = 0;
		comparisons = 0;
		cyc = 0;
		beeps = 0;
		clicks = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_select();
		t_flag();
		t_codes();
		t_irq();
		t_lights();
		t_tones();
		t_repeat(1'b0);
		t_repeat(1'b1);
		conclude();
	end
endmodule : keyboard_io_interface_bench

`default_nettype wire
